// ==== design/cpuhc_pkg.sv ====
// Purpose: Shared constants and helpers for the CPU port frame header codec
// Assumes: Header bit numbers are the least significant bit of each field
// Notes: Register offsets are byte addresses on a 32-bit AXI4-Lite bus
package cpuhc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Extraction header field positions and widths
  localparam int XTR_HDR_W = 128;
  localparam int XTR_SFLOW_LSB = 32;
  localparam int XTR_SFLOW_W = 4;
  localparam int XTR_COPY_HIT_BIT = 31;
  localparam int XTR_DROP_PREC_BIT = 30;
  localparam int XTR_LEARN_LSB = 28;
  localparam int XTR_LEARN_W = 2;
  localparam int XTR_QMASK_LSB = 20;
  localparam int XTR_QMASK_W = 8;
  localparam int XTR_CLASS_LSB = 17;
  localparam int XTR_CLASS_W = 3;
  localparam int XTR_TAG_TYPE_BIT = 16;
  localparam int XTR_PRIO_LSB = 13;
  localparam int XTR_PRIO_W = 3;
  localparam int XTR_DEI_BIT = 12;
  localparam int XTR_VID_LSB = 0;
  localparam int XTR_VID_W = 12;

  // Sampling origin codes
  localparam logic [3:0] SFLOW_RX_SAMPLE = 4'hc;
  localparam logic [3:0] SFLOW_NOT_SAMPLED = 4'hf;

  // Learn action codes
  localparam logic [1:0] LEARN_NONE = 2'h0;
  localparam logic [1:0] LEARN_NEW = 2'h1;
  localparam logic [1:0] LEARN_UPD_UNLOCKED = 2'h2;
  localparam logic [1:0] LEARN_UPD_LOCKED = 2'h3;

  // Tag protocol identifiers
  localparam logic [15:0] TPID_CTAG = 16'h8100;
  localparam logic [15:0] TPID_STAG = 16'h88a8;

  ////////////////////////////////////////////////////////////////////////////
  // Injection header layout: 20 bytes, first word carries bits 159:128
  localparam int INJ_HDR_W = 160;
  localparam logic [2:0] INJ_HDR_WORDS = 3'h5;
  localparam int INJ_SKIP_BIT = 127;
  localparam int INJ_IMP_BIT = 126;
  localparam int INJ_REWRITE_BIT = 126;
  localparam int INJ_IMP_PORT_LSB = 122;
  localparam int INJ_DESTINATION_PORT_SET_LSB = 56;
  localparam int INJ_DESTINATION_PORT_SET_W = 12;
  localparam int INJ_CLASS_LSB = 17;

  // Port numbering inside the switch core
  localparam logic [3:0] CPU_PORT_A = 4'hb;
  localparam logic [3:0] CPU_PORT_B = 4'hc;

  ////////////////////////////////////////////////////////////////////////////
  // Register map and reset values
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CUSTOM_TPID = 8'h04;
  localparam logic [7:0] REG_LAST_XTR = 8'h08;
  localparam logic [7:0] REG_INJ_COUNT = 8'h0c;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [15:0] CUSTOM_TPID_RESET = 16'h9100;
  localparam int CTRL_XTR_INS_LSB = 0;
  localparam int CTRL_INJ_EXP_LSB = 2;
  localparam int CTRL_PRECEDENCE_BIT = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sampling origin: a Tx sample names its port, an Rx sample is code 12
  function automatic logic [3:0] cpuhc_sflow_code(input logic tx, input logic [3:0] port,
                                                 input logic rx);
    if (tx)
      return port;
    else if (rx)
      return SFLOW_RX_SAMPLE;
    else
      return SFLOW_NOT_SAMPLED;
  endfunction

endpackage

// ==== design/cpuhc_inj_collect.sv ====
// Purpose: Splits the injection header from the word stream of one group
// Assumes: One 32-bit word per valid cycle, sof_i marks the first word
// Notes: Without header expect every word passes as frame data
module cpuhc_inj_collect
  import cpuhc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Configuration
  input wire logic expect_i,
  // Word stream from the CPU
  input wire logic [31:0] word_i,
  input wire logic valid_i,
  input wire logic sof_i,
  // Parsed header and frame data
  output logic [cpuhc_pkg::INJ_HDR_W-1:0] hdr_o,
  output logic hdr_valid_o,
  output logic [31:0] data_o,
  output logic data_valid_o
);
  import cpuhc_pkg::*;

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [INJ_HDR_W-1:0] hdr_q;
  logic hdr_valid_q;
  logic [31:0] data_q;
  logic data_valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Word classification: the first five words of an expected header
  wire logic start_hdr = valid_i & sof_i & expect_i;
  wire logic cont_hdr = valid_i & (cnt_q != 3'h0);
  wire logic hdr_word = start_hdr | cont_hdr;
  wire logic last_hdr = hdr_word & (cnt_d == INJ_HDR_WORDS);
  assign cnt_d = start_hdr ? 3'h1 : (cnt_q + 3'h1);

  // Header word counter; a new sof restarts a header cut short
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      cnt_q <= 3'h0;
    else if (last_hdr)
      cnt_q <= 3'h0;
    else if (hdr_word)
      cnt_q <= cnt_d;
  end

  // Header shift register, newest word at the bottom
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      hdr_q <= '0;
      hdr_valid_q <= 1'b0;
    end
    else
    begin
      if (hdr_word)
        hdr_q <= {hdr_q[INJ_HDR_W-33:0], word_i};
      hdr_valid_q <= last_hdr;
    end
  end

  // Frame data after the header, registered once
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      data_q <= 32'h0;
      data_valid_q <= 1'b0;
    end
    else
    begin
      data_valid_q <= valid_i & ~hdr_word;
      if (valid_i & ~hdr_word)
        data_q <= word_i;
    end
  end

  assign hdr_o = hdr_q;
  assign hdr_valid_o = hdr_valid_q;
  assign data_o = data_q;
  assign data_valid_o = data_valid_q;

  // Header words never leak onto the data path
  a_hdr_not_data: assert property (@(posedge clk_i) disable iff (reset_i)
    hdr_word |=> !data_valid_o)
    else $error("Header word passed as frame data");

endmodule // cpuhc_inj_collect

// ==== design/cpuhc_codec.sv ====
// Purpose: Builds CPU extraction headers and decodes CPU injection headers
// Assumes: Classification inputs come from core logic on clk_i
// Notes: Bits above 35 stay zero
// Function
// - Sampling id at bit 32: Tx port 0-11, Rx 12, none 15
// - Bit 31 set when a second-stage rule copies the frame to CPU
// - Bit 30 carries drop precedence after policing
// - Bits 29:28 encode learn action: none, new, unlocked, locked update
// - Eight-bit extraction queue mask at bit 20
// - Three-bit service class at bit 17
// - Bit 16 is 0 for 0x8100 tags, 1 for 0x88a8 or custom
// - Priority at 13, drop eligible at 12, VLAN id at bit 0
// - First 20 injected bytes are a header, not frame data
// - Two independent injection groups on ports 11 and 12
// - Injected frames appear to the core as port 11 unless impersonating
// - Precedence setting prefers port 11 into egress queues
// - Skip bit 127 forwards by header destination, class and tag
// - Skip clear leaves destination, class and VLAN to normal lookups
// - Impersonation bit 126 with skip clear makes the frame appear from the named port
// - Rewrite bit 126 with skip set replaces source MAC per egress port
// - With skip set forward to the 12-bit set at bit 56
// - Extraction header prepended only when the port enables insertion
module cpuhc_codec
  import cpuhc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // AXI4-Lite register slave
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Extraction classification from the core
  input wire logic xtr_req_i,
  input wire logic xtr_port_i,
  input wire logic xtr_tx_sampled_i,
  input wire logic [3:0] xtr_tx_port_i,
  input wire logic xtr_rx_sampled_i,
  input wire logic xtr_rule_hit_i,
  input wire logic xtr_copy_action_i,
  input wire logic xtr_single_hit_i,
  input wire logic xtr_drop_prec_i,
  input wire logic xtr_learn_new_i,
  input wire logic xtr_learn_update_i,
  input wire logic xtr_entry_locked_i,
  input wire logic [7:0] xtr_queue_mask_i,
  input wire logic [2:0] xtr_class_i,
  input wire logic [15:0] xtr_tpid_i,
  input wire logic [2:0] xtr_prio_i,
  input wire logic xtr_dei_i,
  input wire logic [11:0] xtr_vid_i,
  // Extraction header out
  output logic [cpuhc_pkg::XTR_HDR_W-1:0] xtr_hdr_o,
  output logic xtr_hdr_valid_o,
  output logic xtr_hdr_insert_o,
  // Injection word streams, one per group
  input wire logic [1:0][31:0] inj_word_i,
  input wire logic [1:0] inj_valid_i,
  input wire logic [1:0] inj_sof_i,
  // Injection results towards the core
  output logic [1:0] core_hdr_valid_o,
  output logic [1:0][3:0] core_path_port_o,
  output logic [1:0][3:0] core_ingress_port_o,
  output logic [1:0] core_skip_analyzer_o,
  output logic [1:0][11:0] core_destination_port_set_o,
  output logic [1:0][2:0] core_class_o,
  output logic [1:0] core_use_hdr_tag_o,
  output logic [1:0] core_smac_replace_o,
  output logic [1:0][31:0] core_data_o,
  output logic [1:0] core_data_valid_o,
  output logic core_cpu_precedence_o
);
  import cpuhc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus slave
  logic [4:0] ctrl_q;
  logic [15:0] tpid_q;
  logic [31:0] last_xtr_q;
  logic [1:0][15:0] inj_cnt_q;
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Address and data are taken in either order; response follows both
  wire logic aw_take = s_axi_awvalid_i & s_axi_awready_o;
  wire logic w_take = s_axi_wvalid_i & s_axi_wready_o;
  wire logic aw_have = aw_held_q | aw_take;
  wire logic w_have = w_held_q | w_take;
  wire logic wr_fire = aw_have & w_have & ~bvalid_q;
  wire logic [7:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr_i;
  wire logic [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata_i;
  wire logic [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb_i;
  wire logic wr_ctrl = wr_fire & (wr_addr == REG_CTRL);
  wire logic wr_tpid = wr_fire & (wr_addr == REG_CUSTOM_TPID);
  wire logic wr_known = (wr_addr == REG_CTRL) | (wr_addr == REG_CUSTOM_TPID) |
                        (wr_addr == REG_LAST_XTR) | (wr_addr == REG_INJ_COUNT);
  assign s_axi_awready_o = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready_o = ~w_held_q & ~bvalid_q;

  // Write channel holding and response
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
        awaddr_q <= s_axi_awaddr_i;
      if (w_take)
      begin
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      aw_held_q <= aw_have & ~wr_fire;
      w_held_q <= w_have & ~wr_fire;
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready_i)
        bvalid_q <= 1'b0;
    end
  end

  // Software settings; byte lanes honoured
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctrl_q <= CTRL_RESET;
      tpid_q <= CUSTOM_TPID_RESET;
    end
    else
    begin
      if (wr_ctrl & wr_strb[0])
        ctrl_q <= wr_data[4:0];
      if (wr_tpid & wr_strb[0])
        tpid_q[7:0] <= wr_data[7:0];
      if (wr_tpid & wr_strb[1])
        tpid_q[15:8] <= wr_data[15:8];
    end
  end

  // Read decode: unmapped addresses answer zero with an error
  wire logic rd_take = s_axi_arvalid_i & s_axi_arready_o;
  wire logic [31:0] rd_data = (s_axi_araddr_i == REG_CTRL) ? {27'h0, ctrl_q} :
                              (s_axi_araddr_i == REG_CUSTOM_TPID) ? {16'h0, tpid_q} :
                              (s_axi_araddr_i == REG_LAST_XTR) ? last_xtr_q :
                              (s_axi_araddr_i == REG_INJ_COUNT) ? inj_cnt_q : 32'h0;
  wire logic rd_known = (s_axi_araddr_i == REG_CTRL) | (s_axi_araddr_i == REG_CUSTOM_TPID) |
                        (s_axi_araddr_i == REG_LAST_XTR) | (s_axi_araddr_i == REG_INJ_COUNT);
  assign s_axi_arready_o = ~rvalid_q;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_data;
      rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready_i)
      rvalid_q <= 1'b0;
  end

  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Extraction header assembly
  logic [XTR_HDR_W-1:0] xtr_hdr_q;
  logic xtr_valid_q;
  logic xtr_insert_q;

  wire logic [3:0] sflow_code = cpuhc_sflow_code(xtr_tx_sampled_i, xtr_tx_port_i,
                                                 xtr_rx_sampled_i);
  wire logic copy_hit = xtr_rule_hit_i & (xtr_copy_action_i | xtr_single_hit_i);
  wire logic [1:0] learn_code = !(xtr_learn_new_i | xtr_learn_update_i) ? LEARN_NONE :
                                !xtr_learn_update_i ? LEARN_NEW :
                                xtr_entry_locked_i ? LEARN_UPD_LOCKED :
                                LEARN_UPD_UNLOCKED;
  // Custom value equal to 0x8100 still reads as a customer tag
  wire logic tag_is_stag = (xtr_tpid_i != TPID_CTAG) &
                           ((xtr_tpid_i == TPID_STAG) | (xtr_tpid_i == tpid_q));
  wire logic port_inserts = ctrl_q[CTRL_XTR_INS_LSB + int'(xtr_port_i)];

  // Upper fields belong to other logic and stay zero here
  wire logic [XTR_HDR_W-1:0] xtr_hdr_d = {92'h0, sflow_code, copy_hit, xtr_drop_prec_i,
                                          learn_code, xtr_queue_mask_i, xtr_class_i,
                                          tag_is_stag, xtr_prio_i, xtr_dei_i,
                                          xtr_vid_i};

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      xtr_hdr_q <= '0;
      xtr_valid_q <= 1'b0;
      xtr_insert_q <= 1'b0;
      last_xtr_q <= 32'h0;
    end
    else
    begin
      xtr_valid_q <= xtr_req_i;
      if (xtr_req_i)
      begin
        xtr_hdr_q <= xtr_hdr_d;
        xtr_insert_q <= port_inserts;
        last_xtr_q <= xtr_hdr_d[31:0];
      end
    end
  end

  assign xtr_hdr_o = xtr_hdr_q;
  assign xtr_hdr_valid_o = xtr_valid_q;
  assign xtr_hdr_insert_o = xtr_insert_q;

  ////////////////////////////////////////////////////////////////////////////
  // Injection groups: each has its own collector and path into the core
  logic [1:0][INJ_HDR_W-1:0] grp_hdr;
  logic [1:0] grp_hdr_valid;
  logic [1:0] hdr_valid_q;
  logic [1:0][3:0] ingress_q;
  logic [1:0] skip_q;
  logic [1:0][11:0] destination_port_set_q;
  logic [1:0][2:0] class_q;
  logic [1:0] smac_q;

  // Ingress port seen by the core: port 11 unless impersonating
  function automatic logic [3:0] cpuhc_ingress(input logic [INJ_HDR_W-1:0] hdr);
    if (!hdr[INJ_SKIP_BIT] && hdr[INJ_IMP_BIT])
      return hdr[INJ_IMP_PORT_LSB +: 4];
    else
      return CPU_PORT_A;
  endfunction

  for (genvar g = 0; g < 2; g++)
  begin : g_grp
    cpuhc_inj_collect u_collect (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .expect_i(ctrl_q[CTRL_INJ_EXP_LSB + g]),
      .word_i(inj_word_i[g]),
      .valid_i(inj_valid_i[g]),
      .sof_i(inj_sof_i[g]),
      .hdr_o(grp_hdr[g]),
      .hdr_valid_o(grp_hdr_valid[g]),
      .data_o(core_data_o[g]),
      .data_valid_o(core_data_valid_o[g])
    );

    // Decode once per header; skip bit chooses header or analyzer control
    always_ff @(posedge clk_i)
    begin
      if (reset_i)
      begin
        hdr_valid_q[g] <= 1'b0;
        ingress_q[g] <= CPU_PORT_A;
        skip_q[g] <= 1'b0;
        destination_port_set_q[g] <= 12'h0;
        class_q[g] <= 3'h0;
        smac_q[g] <= 1'b0;
        inj_cnt_q[g] <= 16'h0;
      end
      else
      begin
        hdr_valid_q[g] <= grp_hdr_valid[g];
        if (grp_hdr_valid[g])
        begin
          inj_cnt_q[g] <= inj_cnt_q[g] + 16'h1;
          ingress_q[g] <= cpuhc_ingress(grp_hdr[g]);
          skip_q[g] <= grp_hdr[g][INJ_SKIP_BIT];
          destination_port_set_q[g] <= grp_hdr[g][INJ_SKIP_BIT] ?
                       grp_hdr[g][INJ_DESTINATION_PORT_SET_LSB +: INJ_DESTINATION_PORT_SET_W] : 12'h0;
          class_q[g] <= grp_hdr[g][INJ_SKIP_BIT] ? grp_hdr[g][INJ_CLASS_LSB +: 3] : 3'h0;
          smac_q[g] <= grp_hdr[g][INJ_SKIP_BIT] & grp_hdr[g][INJ_REWRITE_BIT];
        end
      end
    end

    assign core_path_port_o[g] = (g == 0) ? CPU_PORT_A : CPU_PORT_B;
  end

  assign core_hdr_valid_o = hdr_valid_q;
  assign core_ingress_port_o = ingress_q;
  assign core_skip_analyzer_o = skip_q;
  assign core_destination_port_set_o = destination_port_set_q;
  assign core_class_o = class_q;
  assign core_use_hdr_tag_o = skip_q;
  assign core_smac_replace_o = smac_q;
  assign core_cpu_precedence_o = ctrl_q[CTRL_PRECEDENCE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_sflow_code: assert property (@(posedge clk_i) disable iff (reset_i)
    xtr_req_i && !xtr_tx_sampled_i && xtr_rx_sampled_i |=> xtr_hdr_o[35:32] == 4'hc)
    else $error("Rx sample code wrong");
  a_copy_hit: assert property (@(posedge clk_i) disable iff (reset_i)
    xtr_req_i |=> xtr_hdr_o[31] == $past(copy_hit))
    else $error("Rule copy hit bit wrong");
  a_drop_prec: assert property (@(posedge clk_i) disable iff (reset_i)
    xtr_req_i |=> xtr_hdr_o[30] == $past(xtr_drop_prec_i))
    else $error("Drop precedence bit wrong");
  a_learn_locked: assert property (@(posedge clk_i) disable iff (reset_i)
    xtr_req_i && xtr_learn_update_i && xtr_entry_locked_i |=> xtr_hdr_o[29:28] == 2'h3)
    else $error("Locked update code wrong");
  a_queue_class: assert property (@(posedge clk_i) disable iff (reset_i)
    xtr_req_i |=> xtr_hdr_o[27:20] == $past(xtr_queue_mask_i) &&
                  xtr_hdr_o[19:17] == $past(xtr_class_i))
    else $error("Queue mask or class misplaced");
  a_ctag_type: assert property (@(posedge clk_i) disable iff (reset_i)
    xtr_req_i && xtr_tpid_i == 16'h8100 |=> !xtr_hdr_o[16])
    else $error("Customer tag marked as service tag");
  a_vlan_fields: assert property (@(posedge clk_i) disable iff (reset_i)
    xtr_req_i |=> xtr_hdr_o[15:0] == {$past(xtr_prio_i), $past(xtr_dei_i), $past(xtr_vid_i)})
    else $error("Tag information misplaced");
  a_insert_gate: assert property (@(posedge clk_i) disable iff (reset_i)
    xtr_valid_q && xtr_insert_q |-> $past(port_inserts))
    else $error("Header inserted on disabled port");
  a_skip_destination_port_set: assert property (@(posedge clk_i) disable iff (reset_i)
    grp_hdr_valid[0] && grp_hdr[0][127] |=> core_destination_port_set_o[0] == $past(grp_hdr[0][67:56]))
    else $error("Bypass destination wrong");
  a_port_eleven: assert property (@(posedge clk_i) disable iff (reset_i)
    grp_hdr_valid[0] && (grp_hdr[0][127] || !grp_hdr[0][126])
    |=> core_ingress_port_o[0] == 4'hb)
    else $error("Injected frame not seen on port 11");
  a_imp_port: assert property (@(posedge clk_i) disable iff (reset_i)
    grp_hdr_valid[0] && !grp_hdr[0][127] && grp_hdr[0][126]
    |=> core_ingress_port_o[0] == $past(grp_hdr[0][125:122]) && !core_smac_replace_o[0])
    else $error("Impersonated port wrong");
  a_smac_replace: assert property (@(posedge clk_i) disable iff (reset_i)
    grp_hdr_valid[0] |=> core_smac_replace_o[0] == $past(grp_hdr[0][127] & grp_hdr[0][126]))
    else $error("Source MAC replace wrong");

endmodule // cpuhc_codec

// ==== verif/cpuhc_cpu_model.sv ====
// Purpose: CPU side model that injects one frame into an injection group
// Assumes: start_i pulses while idle; five header words, then one data word
// Notes: Outside a frame the word lines carry inverted data, never a stale copy
module cpuhc_cpu_model
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Frame to send
  input wire logic start_i,
  input wire logic [159:0] hdr_i,
  input wire logic [31:0] data_i,
  // Word stream
  output logic [31:0] word_o,
  output logic valid_o,
  output logic sof_o
);
  logic [2:0] idx_q;

  ////////////////////////////////////////////////////////////////////////////
  // Word counter, parked at six when idle
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      idx_q <= 3'h6;
    else if (start_i)
      idx_q <= 3'h0;
    else if (valid_o)
      idx_q <= idx_q + 3'h1;
  end

  // Header leads the frame, most significant word first
  assign valid_o = idx_q < 3'h6;
  assign sof_o = idx_q == 3'h0;
  assign word_o = idx_q < 3'h5 ? hdr_i[32*(4-int'(idx_q)) +: 32] :
                  (idx_q == 3'h5 ? data_i : ~data_i);
endmodule // cpuhc_cpu_model

// ==== verif/tb_cpuhc_codec.sv ====
// Purpose: Self-checking bench for the CPU port frame header codec
// Assumes: One 40 MHz clock, synchronous active high reset
// Notes: Extraction cases run from a table; injection goes through the CPU model
module tb_cpuhc_codec
  import cpuhc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [13:0] f; logic [15:0] tpid; logic [26:0] w; logic [35:0] e;}
    cpuhc_row_s;
  logic clk_i = '0, reset_i = '1, start = '0;
  logic [7:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic s_axi_awvalid_i = '0, s_axi_wvalid_i = '0, s_axi_bready_i = '0;
  logic s_axi_arvalid_i = '0, s_axi_rready_i = '0;
  logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o, m_word, last0;
  logic [3:0] s_axi_wstrb_i = 4'hf, xtr_tx_port_i = '0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, inj_valid_i, inj_sof_i;
  logic xtr_req_i = '0, xtr_port_i = '0, xtr_tx_sampled_i = '0, xtr_rx_sampled_i = '0;
  logic xtr_rule_hit_i = '0, xtr_copy_action_i = '0, xtr_single_hit_i = '0;
  logic xtr_drop_prec_i = '0, xtr_learn_new_i = '0, xtr_learn_update_i = '0;
  logic xtr_entry_locked_i = '0, xtr_dei_i = '0, m_valid, m_sof, core_cpu_precedence_o;
  logic [7:0] xtr_queue_mask_i = '0;
  logic [2:0] xtr_class_i = '0, xtr_prio_i = '0;
  logic [15:0] xtr_tpid_i = '0;
  logic [11:0] xtr_vid_i = '0;
  logic [127:0] xtr_hdr_o;
  logic [159:0] hdr = '0;
  logic xtr_hdr_valid_o, xtr_hdr_insert_o;
  logic [1:0][31:0] inj_word_i, core_data_o;
  logic [1:0][3:0] core_path_port_o, core_ingress_port_o;
  logic [1:0][11:0] core_destination_port_set_o;
  logic [1:0][2:0] core_class_o;
  logic [1:0] core_hdr_valid_o, core_skip_analyzer_o, core_use_hdr_tag_o;
  logic [1:0] core_smac_replace_o, core_data_valid_o;
  int bad_count = 0, n_checks = 0, dv0 = 0, dv1 = 0, cyc = 0;
  // Flags, tpid, wide fields, expected header bits 35:0
  cpuhc_row_s rows [4] = '{'{14'h1bec, 16'h8100, 27'h40d7fff, 36'hbd81a7fff},
    '{14'h23d7, 16'h88a8, 27'h0000000, 36'hcb0010000},
    '{14'h0032, 16'h9100, 27'h2d7a123, 36'hf25afa123},
    '{14'h3048, 16'h8100, 27'h7f8f800, 36'h04ff0f800}};

  ////////////////////////////////////////////////////////////////////////////
  // Group 1 sees the same stream but never expects a header
  assign inj_word_i = {m_word, m_word};
  assign inj_valid_i = {m_valid, m_valid};
  assign inj_sof_i = {m_sof, m_sof};
  cpuhc_codec u_cpuhc_codec (.clk_i, .reset_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .xtr_req_i, .xtr_port_i, .xtr_tx_sampled_i, .xtr_tx_port_i, .xtr_rx_sampled_i,
    .xtr_rule_hit_i, .xtr_copy_action_i, .xtr_single_hit_i, .xtr_drop_prec_i,
    .xtr_learn_new_i, .xtr_learn_update_i, .xtr_entry_locked_i, .xtr_queue_mask_i,
    .xtr_class_i, .xtr_tpid_i, .xtr_prio_i, .xtr_dei_i, .xtr_vid_i, .xtr_hdr_o,
    .xtr_hdr_valid_o, .xtr_hdr_insert_o, .inj_word_i, .inj_valid_i, .inj_sof_i,
    .core_hdr_valid_o, .core_path_port_o, .core_ingress_port_o, .core_skip_analyzer_o,
    .core_destination_port_set_o, .core_class_o, .core_use_hdr_tag_o, .core_smac_replace_o, .core_data_o,
    .core_data_valid_o, .core_cpu_precedence_o);
  cpuhc_cpu_model u_cpuhc_cpu_model (.clk_i, .reset_i, .start_i(start), .hdr_i(hdr),
    .data_i(32'hd00d0001), .word_o(m_word), .valid_o(m_valid), .sof_o(m_sof));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, data word tally and hang guard
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (core_data_valid_o[0] === 1'b1)
    begin
      dv0 <= dv0 + 1;
      last0 <= core_data_o[0];
    end
    if (core_data_valid_o[1] === 1'b1)
      dv1 <= dv1 + 1;
    if (cyc == 2000)
    begin
      bad_count++;
      conclude();
    end
  end

  task automatic chk(input logic [159:0] s, input logic [159:0] e, input string n);
    n_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    chk(s_axi_bresp_o, r, "bresp");
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    chk({s_axi_rresp_o, s_axi_rdata_o}, {r, e}, "read");
  endtask

  task automatic inject(input logic [159:0] h);
    hdr <= h;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    do @(posedge clk_i); while (core_hdr_valid_o[0] !== 1'b1);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    chk({core_path_port_o, core_ingress_port_o, core_cpu_precedence_o}, 17'h19776,
        "ports");
    axr(REG_CTRL, 32'h0, RESP_OKAY);
    axr(REG_CUSTOM_TPID, 32'h9100, RESP_OKAY);
    axr(8'h10, 32'h0, RESP_SLVERR);
    axw(8'h20, 32'h1, RESP_SLVERR);
    axw(REG_CTRL, 32'h15, RESP_OKAY);
    chk(core_cpu_precedence_o, 1'b1, "precedence");
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      {xtr_port_i, xtr_tx_sampled_i, xtr_tx_port_i, xtr_rx_sampled_i, xtr_rule_hit_i,
       xtr_copy_action_i, xtr_single_hit_i, xtr_drop_prec_i, xtr_learn_new_i,
       xtr_learn_update_i, xtr_entry_locked_i} <= rows[i].f;
      xtr_tpid_i <= rows[i].tpid;
      {xtr_queue_mask_i, xtr_class_i, xtr_prio_i, xtr_dei_i, xtr_vid_i} <= rows[i].w;
      xtr_req_i <= 1'b1;
      @(posedge clk_i);
      xtr_req_i <= 1'b0;
      #1;
      chk({xtr_hdr_valid_o, xtr_hdr_o}, {1'b1, 92'h0, rows[i].e}, "hdr");
      chk(xtr_hdr_insert_o, {~rows[i].f[13]}, "insert");
      @(posedge clk_i);
    end
    axw(REG_LAST_XTR, 32'hffffffff, RESP_OKAY);
    axr(REG_LAST_XTR, 32'h4ff0f800, RESP_OKAY);
    $display("test extraction done");
    // Unused header bits stay zero
    inject({32'h0, 2'h3, 58'h0, 12'h805, 36'h0, 3'h6, 17'h0});
    chk({core_skip_analyzer_o[0], core_use_hdr_tag_o[0], core_smac_replace_o[0],
         core_destination_port_set_o[0], core_class_o[0], core_ingress_port_o[0]},
        {3'h7, 12'h805, 3'h6, 4'hb}, "skip frame");
    inject({32'h0, 2'h1, 4'h5, 54'h0, 12'h805, 36'h0, 3'h6, 17'h0});
    chk({core_skip_analyzer_o[0], core_use_hdr_tag_o[0], core_smac_replace_o[0],
         core_destination_port_set_o[0], core_class_o[0], core_ingress_port_o[0]},
        {3'h0, 12'h0, 3'h0, 4'h5}, "analyzed frame");
    repeat (3) @(posedge clk_i);
    chk({dv0, dv1, last0, core_data_o[1]}, {32'd2, 32'd12, 32'hd00d0001, 32'hd00d0001},
        "data words");
    axr(REG_INJ_COUNT, 32'h2, RESP_OKAY);
    $display("test injection done");
    conclude();
  end
endmodule // tb_cpuhc_codec
